// File: core/icu_pkg.sv
// Package: register map, field positions and enumerations of the input capture unit
package icu_pkg;

   // Register byte addresses (chosen, word aligned)
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_BUF      = 8'h04;
   localparam logic [7:0] ADDR_TIMERS   = 8'h08;
   localparam logic [7:0] ADDR_PWR      = 8'h0C;

   // Control register field positions
   localparam int         POS_SIDL      = 13;
   localparam int         POS_TSEL      = 7;
   localparam int         POS_CPI       = 5;
   localparam int         POS_OVF       = 4;
   localparam int         POS_BNE       = 3;
   localparam int         POS_MODE      = 0;

   // Reset values
   localparam logic [15:0] CTRL_RESET   = 16'h0000;

   // Capture buffer depth
   localparam int         BUF_DEPTH     = 4;
   localparam int         BUF_AW        = 2;

   // Prescaler terminal counts (edges minus one)
   localparam logic [3:0] PRE_DIV4      = 4'h3;
   localparam logic [3:0] PRE_DIV16     = 4'hF;

   // Power-state bits in the power register
   localparam int         POS_IDLE      = 0;
   localparam int         POS_SLEEP     = 1;

   // Capture modes
   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_BOTH   = 3'h1,
      MODE_FALL   = 3'h2,
      MODE_RISE   = 3'h3,
      MODE_RISE4  = 3'h4,
      MODE_RISE16 = 3'h5,
      MODE_UNUSED = 3'h6,
      MODE_WAKE   = 3'h7
   } icu_mode_t;

   // Writable control fields
   typedef struct packed {
      logic       stop_in_idle;
      logic       timer_select;
      logic [1:0] captures_per_interrupt;
      logic [2:0] capture_mode_select;
   } icu_ctrl_t;

   // Edge events of the input pin
   typedef struct packed {
      logic rise;
      logic fall;
   } icu_edge_t;

endpackage

// File: core/icu_edge_detect.sv
// Two-flop synchroniser and edge detector for the capture pin
`timescale 1ns/1ps
module icu_edge_detect (
   // Clock and reset
   input  wire logic            hclk,
   input  wire logic            hresetn,
   // Pin and edges
   input  wire logic            pin_in,
   output icu_pkg::icu_edge_t   edge_o
);

   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_last;

   // Next values; only sync_ff reads meta_ff
   always_comb begin
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
      nxt_last = sync_ff;
   end

   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end

   // Edges are pulses of one cycle
   assign edge_o.rise = sync_ff & ~last_ff;
   assign edge_o.fall = ~sync_ff & last_ff;

endmodule

// File: core/icu_capture_fifo.sv
// Small capture buffer of timer values with overflow report
`timescale 1ns/1ps
module icu_capture_fifo (
   // Clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // Control
   input  wire logic          clear,
   input  wire logic          push,
   input  wire logic [15:0]   push_data,
   input  wire logic          pop,
   // Status and data
   output logic [15:0]        head_data,
   output logic               not_empty,
   output logic               overflow
);

   logic [15:0]                mem_ff [icu_pkg::BUF_DEPTH];
   logic [15:0]                nxt_mem [icu_pkg::BUF_DEPTH];
   logic [icu_pkg::BUF_AW-1:0] wr_ff;
   logic [icu_pkg::BUF_AW-1:0] rd_ff;
   logic [icu_pkg::BUF_AW:0]   cnt_ff;
   logic                       ovf_ff;
   logic [icu_pkg::BUF_AW-1:0] nxt_wr;
   logic [icu_pkg::BUF_AW-1:0] nxt_rd;
   logic [icu_pkg::BUF_AW:0]   nxt_cnt;
   logic                       nxt_ovf;
   logic                       do_push;
   logic                       do_pop;

   // A push into a full buffer with no pop in the same cycle is dropped and flags overflow; the
   // overflow set is sticky until the channel is turned off
   always_comb begin
      do_pop  = pop && (cnt_ff != '0);
      do_push = push && ((cnt_ff != 3'(icu_pkg::BUF_DEPTH)) || do_pop);
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      nxt_ovf = ovf_ff;
      if (do_push) begin
         nxt_mem[wr_ff] = push_data;
         nxt_wr         = wr_ff + 2'h1;
      end
      if (do_pop) begin
         nxt_rd = rd_ff + 2'h1;
      end
      if (do_push && !do_pop) begin
         nxt_cnt = cnt_ff + 3'h1;
      end else if (do_pop && !do_push) begin
         nxt_cnt = cnt_ff - 3'h1;
      end
      if (clear) begin
         nxt_wr  = '0;
         nxt_rd  = '0;
         nxt_cnt = '0;
         nxt_ovf = 1'b0;
      end
      if (push && !do_push) begin
         nxt_ovf = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < icu_pkg::BUF_DEPTH; i++) begin
            mem_ff[i] <= 16'h0000;
         end
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
         ovf_ff <= 1'b0;
      end else begin
         mem_ff <= nxt_mem;
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ovf_ff <= nxt_ovf;
      end
   end

   assign head_data = mem_ff[rd_ff];
   assign not_empty = (cnt_ff != '0);
   assign overflow  = ovf_ff;

endmodule

// File: core/icu_top.sv
// Input capture channel with AHB-Lite register slave
// Overview of operation
// - stop-in-idle set halts capture during Idle; mode 111 wake requests still fire
// - timer select picks second or third timer
// - captures-per-interrupt sets captures per request, except mode 001 requests on every capture
// - overflow flag set on capture buffer overflow
// - buffer-not-empty reads one while data remains
// - mode 111 is sleep/idle rising-edge wake only
// - mode 110 behaves as disabled
// - modes 101/100 capture every 16th/4th rise
// - modes 011/010 capture every rise/fall
// - mode 000 turns channel off
// - status cleared by hardware; control resets zero
// - unimplemented control bits read as zero
`timescale 1ns/1ps
module icu_top (
   // Clock and reset
   input  wire logic            hclk,
   input  wire logic            hresetn,
   // AHB-Lite slave
   input  wire logic            hsel,
   input  wire logic [7:0]      haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic [31:0]          hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   // Timers and pin
   input  wire logic [15:0]     second_timer_count,
   input  wire logic [15:0]     third_timer_count,
   input  wire logic            capture_pin,
   // Power state and request
   input  wire logic            cpu_idle,
   input  wire logic            cpu_sleep,
   output logic                 capture_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   icu_pkg::icu_ctrl_t  ctrl_ff;
   icu_pkg::icu_ctrl_t  nxt_ctrl;
   icu_pkg::icu_edge_t  edge_w;
   icu_pkg::icu_mode_t  mode_w;
   logic                wr_pend_ff;
   logic                nxt_wr_pend;
   logic                rd_pend_ff;
   logic                nxt_rd_pend;
   logic [7:0]          addr_ff;
   logic [7:0]          nxt_addr;
   logic [31:0]         rdata_ff;
   logic [31:0]         nxt_rdata;
   logic [3:0]          pre_ff;
   logic [3:0]          nxt_pre;
   logic [1:0]          cpi_ff;
   logic [1:0]          nxt_cpi;
   logic                irq_ff;
   logic                nxt_irq;
   logic                idle_s1_ff;
   logic                idle_s2_ff;
   logic                sleep_s1_ff;
   logic                sleep_s2_ff;
   logic                nxt_idle_s1;
   logic                nxt_idle_s2;
   logic                nxt_sleep_s1;
   logic                nxt_sleep_s2;
   logic                addr_phase;
   logic                halted;
   logic                enabled;
   logic                evt_edge;
   logic                capture;
   logic                fifo_clear;
   logic                fifo_pop;
   logic [15:0]         fifo_head;
   logic                fifo_ne;
   logic                fifo_ovf;
   logic [15:0]         ctrl_rd;
   logic [15:0]         timer_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Submodules

   // Pin synchroniser and one-cycle edge pulses
   icu_edge_detect u_edge (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (capture_pin),
      .edge_o  (edge_w)
   );

   // Four-entry capture buffer; a push into a full buffer with no pop in the same cycle is lost and sets
   // overflow, which stays set until the mode field turns the channel off
   icu_capture_fifo u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .clear     (fifo_clear),
      .push      (capture),
      .push_data (timer_sel),
      .pop       (fifo_pop),
      .head_data (fifo_head),
      .not_empty (fifo_ne),
      .overflow  (fifo_ovf)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power state inputs come from another block's logic; synchronise them
   // anyway so the channel tolerates an asynchronous power controller.
   // The price is two cycles of lag on entering and leaving Idle or Sleep,
   // which only shifts the moment a halt or a wake request takes effect

   // Next values; only the second stage reads the first
   always_comb begin
      nxt_idle_s1  = cpu_idle;
      nxt_idle_s2  = idle_s1_ff;
      nxt_sleep_s1 = cpu_sleep;
      nxt_sleep_s2 = sleep_s1_ff;
   end

   // Synchroniser registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_s1_ff  <= 1'b0;
         idle_s2_ff  <= 1'b0;
         sleep_s1_ff <= 1'b0;
         sleep_s2_ff <= 1'b0;
      end else begin
         idle_s1_ff  <= nxt_idle_s1;
         idle_s2_ff  <= nxt_idle_s2;
         sleep_s1_ff <= nxt_sleep_s1;
         sleep_s2_ff <= nxt_sleep_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and capture event; wake mode captures nothing and only
   // raises requests from the rising-edge path further down

   always_comb begin
      mode_w     = icu_pkg::icu_mode_t'(ctrl_ff.capture_mode_select);
      halted     = ctrl_ff.stop_in_idle && idle_s2_ff;
      enabled    = !halted && (mode_w != icu_pkg::MODE_OFF)
                   && (mode_w != icu_pkg::MODE_UNUSED)
                   && (mode_w != icu_pkg::MODE_WAKE);
      fifo_clear = (mode_w == icu_pkg::MODE_OFF) || (mode_w == icu_pkg::MODE_UNUSED);
      timer_sel  = ctrl_ff.timer_select ? second_timer_count : third_timer_count;
      case (mode_w)
         icu_pkg::MODE_BOTH:   evt_edge = edge_w.rise | edge_w.fall;
         icu_pkg::MODE_FALL:   evt_edge = edge_w.fall;
         icu_pkg::MODE_RISE,
         icu_pkg::MODE_RISE4,
         icu_pkg::MODE_RISE16: evt_edge = edge_w.rise;
         default:              evt_edge = 1'b0;
      endcase
      capture = 1'b0;
      case (mode_w)
         icu_pkg::MODE_RISE4:  capture = evt_edge && (pre_ff[1:0] == icu_pkg::PRE_DIV4[1:0]);
         icu_pkg::MODE_RISE16: capture = evt_edge && (pre_ff == icu_pkg::PRE_DIV16);
         default:              capture = evt_edge;
      endcase
      capture = capture && enabled;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge prescaler for the divide-by-4 and divide-by-16 modes. It restarts
   // whenever the channel is not enabled, so the first capture after the channel
   // is enabled again lands on the 4th or 16th qualifying edge

   always_comb begin
      nxt_pre = pre_ff;
      if (!enabled) begin
         nxt_pre = 4'h0;
      end else if (evt_edge) begin
         nxt_pre = pre_ff + 4'h1;
         if (mode_w == icu_pkg::MODE_RISE4 && pre_ff[1:0] == icu_pkg::PRE_DIV4[1:0]) begin
            nxt_pre = 4'h0;
         end
      end
   end

   // Prescaler register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_ff <= 4'h0;
      end else begin
         pre_ff <= nxt_pre;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture-per-request counter and request output

   always_comb begin
      nxt_cpi = cpi_ff;
      nxt_irq = 1'b0;
      if (!enabled) begin
         nxt_cpi = 2'h0;
      end
      if (capture) begin
         if (mode_w == icu_pkg::MODE_BOTH) begin
            nxt_irq = 1'b1;
         end else if (cpi_ff == ctrl_ff.captures_per_interrupt) begin
            nxt_irq = 1'b1;
            nxt_cpi = 2'h0;
         end else begin
            nxt_cpi = cpi_ff + 2'h1;
         end
      end
      // Wake mode: rising edge requests only in Sleep or Idle
      if (mode_w == icu_pkg::MODE_WAKE && edge_w.rise && (sleep_s2_ff || idle_s2_ff)) begin
         nxt_irq = 1'b1;
      end
   end

   // Request registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpi_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         cpi_ff <= nxt_cpi;
         irq_ff <= nxt_irq;
      end
   end

   assign capture_irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Control word as software reads it; gaps are tied low and the status
   // bits come straight from the buffer, so no write can reach them

   always_comb begin
      ctrl_rd = icu_pkg::CTRL_RESET;
      ctrl_rd[icu_pkg::POS_SIDL]     = ctrl_ff.stop_in_idle;
      ctrl_rd[icu_pkg::POS_TSEL]     = ctrl_ff.timer_select;
      ctrl_rd[icu_pkg::POS_CPI +: 2] = ctrl_ff.captures_per_interrupt;
      ctrl_rd[icu_pkg::POS_OVF]      = fifo_ovf;
      ctrl_rd[icu_pkg::POS_BNE]      = fifo_ne;
      ctrl_rd[icu_pkg::POS_MODE +: 3] = ctrl_ff.capture_mode_select;
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY. hsize is not decoded:
   // every register is one whole word. A buffer read pops in its address
   // phase, so the entry is consumed even if the master ignores the data

   always_comb begin
      addr_phase  = hsel && hready && htrans[1];
      nxt_wr_pend = addr_phase && hwrite;
      nxt_rd_pend = addr_phase && !hwrite;
      nxt_addr    = addr_phase ? haddr : addr_ff;
      nxt_ctrl    = ctrl_ff;
      // Status bits are never written: only hardware clears them
      if (wr_pend_ff && addr_ff == icu_pkg::ADDR_CTRL) begin
         nxt_ctrl.stop_in_idle           = hwdata[icu_pkg::POS_SIDL];
         nxt_ctrl.timer_select           = hwdata[icu_pkg::POS_TSEL];
         nxt_ctrl.captures_per_interrupt = hwdata[icu_pkg::POS_CPI +: 2];
         nxt_ctrl.capture_mode_select    = hwdata[icu_pkg::POS_MODE +: 3];
      end
      // Read data is latched in the address phase; a buffer read pops
      nxt_rdata = 32'h0000_0000;
      fifo_pop  = 1'b0;
      if (nxt_rd_pend) begin
         case (haddr)
            icu_pkg::ADDR_CTRL:   nxt_rdata = {16'h0000, ctrl_rd};
            icu_pkg::ADDR_BUF: begin
               nxt_rdata = {16'h0000, fifo_head};
               fifo_pop  = 1'b1;
            end
            icu_pkg::ADDR_TIMERS: nxt_rdata = {second_timer_count, third_timer_count};
            icu_pkg::ADDR_PWR: begin
               nxt_rdata[icu_pkg::POS_IDLE]  = idle_s2_ff;
               nxt_rdata[icu_pkg::POS_SLEEP] = sleep_s2_ff;
            end
            default:              nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff    <= icu_pkg::icu_ctrl_t'(7'h00);
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         wr_pend_ff <= nxt_wr_pend;
         rd_pend_ff <= nxt_rd_pend;
         addr_ff    <= nxt_addr;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign hrdata    = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule

// File: testbench/icu_top_props.sv
// Checker of bus answers and capture requests at the input capture channel ports
`timescale 1ns/1ps
module icu_top_props (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Register bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Timers, pin and power state
   input wire logic [15:0] second_timer_count,
   input wire logic [15:0] third_timer_count,
   input wire logic        capture_pin,
   input wire logic        cpu_idle,
   input wire logic        cpu_sleep,
   input wire logic        capture_irq
);
   logic       acc;
   logic       rd_ph_ff;
   logic       wr_ph_ff;
   logic       pin_ff;
   logic [7:0] rd_addr_ff;
   logic [2:0] mode_ff;
   logic [3:0] wr_age_ff;
   logic [3:0] pin_age_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Accepted address phase
   assign acc = hsel & hready & htrans[1];

   // Shadow of the mode field; ages saturate so old events stop mattering
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph_ff   <= 1'b0;
         wr_ph_ff   <= 1'b0;
         pin_ff     <= 1'b0;
         rd_addr_ff <= 8'h00;
         mode_ff    <= 3'h0;
         wr_age_ff  <= 4'hF;
         pin_age_ff <= 4'hF;
      end else begin
         rd_ph_ff   <= acc & ~hwrite;
         wr_ph_ff   <= acc & hwrite & (haddr == icu_pkg::ADDR_CTRL);
         pin_ff     <= capture_pin;
         rd_addr_ff <= haddr;
         if (wr_ph_ff) begin
            mode_ff <= hwdata[2:0];
         end
         wr_age_ff  <= wr_ph_ff ? 4'h0 : ((wr_age_ff == 4'hF) ? 4'hF : wr_age_ff + 4'h1);
         pin_age_ff <= (pin_ff != capture_pin) ? 4'h0 : ((pin_age_ff == 4'hF) ? 4'hF : pin_age_ff + 4'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One clock domain for all properties
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Both power inputs low long enough to pass the synchroniser
   sequence s_awake;
      (!cpu_idle && !cpu_sleep) [*6];
   endsequence

   a_irq_one_cycle: assert property (capture_irq |=> !capture_irq)
      else $error("capture request wider than one cycle");
   a_irq_after_edge: assert property (capture_irq |-> pin_age_ff inside {[2:6]})
      else $error("capture request without a recent pin edge");
   a_off_quiet: assert property ((mode_ff == 3'h0 && wr_age_ff > 4'h6) |-> !capture_irq)
      else $error("request while channel off");
   a_unused_quiet: assert property ((mode_ff == 3'h6 && wr_age_ff > 4'h6) |-> !capture_irq)
      else $error("request in unused mode");
   a_wake_only_asleep: assert property (s_awake ##0 (mode_ff == 3'h7 && wr_age_ff > 4'h6) |-> !capture_irq)
      else $error("wake request while running");
   a_ctrl_gaps_zero: assert property ((rd_ph_ff && rd_addr_ff == icu_pkg::ADDR_CTRL)
                                      |-> (hrdata[31:14] == 18'h0 && hrdata[12:8] == 5'h0))
      else $error("unimplemented control bits read nonzero");
   a_unmapped_zero: assert property ((rd_ph_ff && rd_addr_ff > icu_pkg::ADDR_PWR) |-> hrdata == 32'h0)
      else $error("unmapped read nonzero");
   a_off_status_clear: assert property ((rd_ph_ff && rd_addr_ff == icu_pkg::ADDR_CTRL && mode_ff == 3'h0
                                         && wr_age_ff > 4'h3) |-> hrdata[4:3] == 2'h0)
      else $error("status bits not cleared with channel off");
endmodule

bind icu_top icu_top_props chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .second_timer_count(second_timer_count), .third_timer_count(third_timer_count),
   .capture_pin(capture_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(capture_irq)
);

// File: testbench/icu_pin_drv.sv
// External signal source that drives the capture pin
`timescale 1ns/1ps
module icu_pin_drv (
   // Clock
   input  wire logic hclk,
   // Pin
   output logic      pin_o
);
   // Push-pull source, idle low
   initial pin_o = 1'b0;

   // Toggles n times, eight clocks apart so the synchroniser sees every level
   task automatic toggle_run(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (8) @(posedge hclk);
         pin_o <= ~pin_o;
      end
   endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking testbench of the input capture channel
`timescale 1ns/1ps
module tb_top;
   localparam logic [15:0] T2 = 16'h1234;
   localparam logic [15:0] T3 = 16'hABCD;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] second_timer_count, third_timer_count;
   logic        capture_pin, cpu_idle, cpu_sleep, capture_irq;
   int          bad_count, n_compared, irq_cnt, base;
   // Scenarios: control word, power state {sleep,idle}, requests, values buffered, overflow
   logic [15:0] t_ctrl [13] = '{16'h0061, 16'h00C2, 16'h0063, 16'h00A4, 16'h0005, 16'h0006, 16'h00E0,
                                16'h0007, 16'h20E7, 16'h0007, 16'h2083, 16'h2083, 16'h0083};
   logic [1:0]  t_pwr [13]  = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1};
   int          t_irq [13]  = '{32, 5, 4, 2, 1, 0, 0, 0, 16, 16, 0, 16, 16};
   int          t_buf [13]  = '{4, 4, 4, 4, 1, 0, 0, 0, 0, 0, 0, 4, 4};
   logic        t_ovf [13]  = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and instances
   initial hclk = 1'b0;
   always #25 hclk = ~hclk;

   icu_top dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .second_timer_count(second_timer_count), .third_timer_count(third_timer_count),
      .capture_pin(capture_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(capture_irq)
   );
   icu_pin_drv pin_u (.hclk(hclk), .pin_o(capture_pin));

   // Counts request pulses; scenarios compare differences, so no reset race
   always @(posedge hclk) begin
      if (capture_irq === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison and closing report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_ready;
      int k;
      for (k = 0; k < 50; k++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (k == 50) begin
         bad_count++;
         $display("[ERR] %0t bus never ready", $time);
         finish_test();
      end
   endtask

   // Single word transfer: address phase, then data phase; read data taken at its closing edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      r = hrdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; second_timer_count = T2; third_timer_count = T3; cpu_idle = 1'b0; cpu_sleep = 1'b0;
      bad_count = 0; n_compared = 0; irq_cnt = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h0, "control after reset");
      xfer(1'b1, icu_pkg::ADDR_CTRL, 32'hFFFF_FFFF, rd);
      xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h0000_20E7, "control writable bits");
      xfer(1'b0, 8'h10, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      xfer(1'b0, icu_pkg::ADDR_TIMERS, 32'h0, rd);
      check(rd, {T2, T3}, "timer view");
      for (int i = 0; i < 13; i++) begin
         cpu_idle  <= t_pwr[i][0];
         cpu_sleep <= t_pwr[i][1];
         xfer(1'b1, icu_pkg::ADDR_CTRL, 32'h0, rd);
         repeat (4) @(posedge hclk);
         xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, rd);
         check(rd, 32'h0, "status after off");
         xfer(1'b0, icu_pkg::ADDR_PWR, 32'h0, rd);
         check(rd, {30'h0, t_pwr[i]}, "power state");
         xfer(1'b1, icu_pkg::ADDR_CTRL, {16'h0, t_ctrl[i]}, rd);
         base = irq_cnt;
         pin_u.toggle_run(32);
         repeat (10) @(posedge hclk);
         check(32'(irq_cnt - base), 32'(t_irq[i]), "request count");
         xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, rd);
         check(rd, {16'h0, t_ctrl[i] | {11'h0, t_ovf[i], t_buf[i] != 0, 3'h0}}, "status");
         if (t_buf[i] != 0) begin
            xfer(1'b0, icu_pkg::ADDR_BUF, 32'h0, rd);
            check(rd, {16'h0, t_ctrl[i][7] ? T2 : T3}, "captured timer");
            xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, rd);
            check({31'h0, rd[3]}, {31'h0, t_buf[i] > 1}, "not empty after pop");
         end
      end
      xfer(1'b1, icu_pkg::ADDR_CTRL, 32'h0, rd);
      finish_test();
   end
endmodule
